// File: verification/rstc_top_assertions.sv
// Concurrent checks on the status, validity, trim and clock output ports
`timescale 1ns/1ps
module rstc_top_assertions
  import rstc_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES_P = 16
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       alarm_match_i,
  input  wire logic       time_regs_reset_i,
  input  wire logic       coin_cell_low_i,
  input  wire logic       osc_rc_active_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       interrupt_request_o,
  input  wire logic       time_advance_o,
  input  wire logic       time_advance_double_o,
  input  wire logic       set_mode_o,
  input  wire logic       hour_24_mode_o,
  input  wire logic       binary_mode_o,
  input  wire logic       time_valid_o,
  input  wire logic       slow_clk_out_en_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  clk_out_mask_a: assert property (
    reg_wr_i && reg_addr_i == ADDR_SLOW_CLOCK_OUTPUT_MASK_MASK |=> ##1
    slow_clk_out_en_o == !$past(reg_wdata_i[0], 2))
    else $error("clock output enable does not follow mask write");
  valid_read_set_a: assert property (
    reg_rd_i && reg_addr_i == ADDR_VALIDITY && !time_regs_reset_i |=> time_valid_o)
    else $error("time valid not set by validity read");
  valid_clear_a: assert property (
    time_regs_reset_i |=> !time_valid_o)
    else $error("time valid not cleared by time reset");
  valid_keep_a: assert property (
    !time_valid_o && !(reg_rd_i && reg_addr_i == ADDR_VALIDITY) |=> !time_valid_o)
    else $error("time valid set without validity read");
  set_stops_tick_a: assert property (
    set_mode_o [*2] |-> !time_advance_o)
    else $error("time advanced in set mode");
  tick_spacing_a: assert property (
    time_advance_o |=> !time_advance_o [*8])
    else $error("time advance pulses too close");
  read_clears_a: assert property (
    reg_rd_i && reg_addr_i == ADDR_INT_STATUS && !time_advance_o && !$past(time_advance_o)
    && !alarm_match_i && !$past(alarm_match_i) |=> !interrupt_request_o)
    else $error("status read left request flag high");
  irq_cause_a: assert property (
    $rose(interrupt_request_o) |-> $past(time_advance_o) || $past(alarm_match_i)
    || $past(alarm_match_i, 2) || $past(reg_wr_i && reg_addr_i == ADDR_CONTROL))
    else $error("request flag rose without a cause");
  double_with_tick_a: assert property (
    time_advance_double_o |-> time_advance_o)
    else $error("double count without time advance");
endmodule

bind rstc_top rstc_top_assertions #(.SECOND_CYCLES_P(SECOND_CYCLES_P)) u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .alarm_match_i(alarm_match_i),
  .time_regs_reset_i(time_regs_reset_i), .coin_cell_low_i(coin_cell_low_i),
  .osc_rc_active_i(osc_rc_active_i), .reg_rdata_o(reg_rdata_o),
  .interrupt_request_o(interrupt_request_o), .time_advance_o(time_advance_o),
  .time_advance_double_o(time_advance_double_o), .set_mode_o(set_mode_o),
  .hour_24_mode_o(hour_24_mode_o), .binary_mode_o(binary_mode_o),
  .time_valid_o(time_valid_o), .slow_clk_out_en_o(slow_clk_out_en_o));

// File: verification/rstc_top_tb.sv
// Self-checking testbench for the clock status, validity and trim registers
`timescale 1ns/1ps
module rstc_top_tb;
  import rstc_pkg::*;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic [7:0] addr = 8'h00;
  logic       wr   = 1'b0;
  logic       rd   = 1'b0;
  logic [7:0] wd   = 8'h00;
  logic       am   = 1'b0;
  logic       trr  = 1'b0;
  logic       ccl  = 1'b0;
  logic       osc  = 1'b1;
  logic [7:0] rdata;
  logic       irq, adv, dbl, setm, h24, bin, tv, cen;
  logic [7:0] d, t, db;
  int         err_count = 0;
  int         checked   = 0;

  // Short second keeps the trim window within a few thousand cycles
  rstc_top #(.SECOND_CYCLES_P(16)) u_dut (
    .ref_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wd), .alarm_match_i(am), .time_regs_reset_i(trr), .coin_cell_low_i(ccl),
    .osc_rc_active_i(osc), .reg_rdata_o(rdata), .interrupt_request_o(irq),
    .time_advance_o(adv), .time_advance_double_o(dbl), .set_mode_o(setm),
    .hour_24_mode_o(h24), .binary_mode_o(bin), .time_valid_o(tv), .slow_clk_out_en_o(cen));

  always #25 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wd = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Read data lands at the strobe edge, so it is taken one negedge later
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v = rdata;
  endtask

  task automatic wait_tick();
    int i;
    i = 0;
    while (adv !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    chk({7'h00, adv}, 8'h01, "no time advance");
  endtask

  task automatic count_ticks(input int n, output logic [7:0] tk, output logic [7:0] dk);
    tk = 0;
    dk = 0;
    repeat (n) begin
      @(negedge clk);
      if (adv === 1'b1) tk++;
      if (dbl === 1'b1) dk++;
    end
  endtask

  task automatic t_reset();
    logic [7:0] tbl [8][2] = '{'{8'h1C, 8'h00}, '{8'h1D, 8'h00}, '{8'h1E, 8'h05},
      '{8'h1F, 8'h00}, '{8'h20, 8'h00}, '{8'h21, 8'h00}, '{8'h1B, 8'h02}, '{8'h30, 8'h00}};
    for (int i = 0; i < 8; i++) begin
      rreg(tbl[i][0], d);
      chk(d, tbl[i][1], "reset value");
    end
    chk({7'h00, cen}, 8'h01, "clock output after reset");
    chk({6'h00, bin, h24}, 8'h01, "mode outputs after reset");
  endtask

  task automatic t_regs();
    logic [7:0] tbl [5][3] = '{'{8'h1F, 8'hFF, 8'h01}, '{8'h20, 8'hFF, 8'h7F},
      '{8'h21, 8'hFF, 8'h01}, '{8'h1E, 8'hF8, 8'hF9}, '{8'h1B, 8'hFF, 8'hB6}};
    for (int i = 0; i < 5; i++) begin
      wreg(tbl[i][0], tbl[i][1]);
      rreg(tbl[i][0], d);
      chk(d, tbl[i][2], "register readback");
    end
    chk({6'h00, bin, h24}, 8'h03, "mode outputs after write");
    chk({7'h00, cen}, 8'h00, "clock output masked");
    wreg(8'h21, 8'h00);
    cyc(1);
    chk({7'h00, cen}, 8'h01, "clock output enabled");
    wreg(8'h1F, 8'h00);
    wreg(8'h20, 8'h00);
  endtask

  task automatic t_valid();
    @(negedge clk);
    trr = 1'b1;
    @(negedge clk);
    trr = 1'b0;
    chk({7'h00, tv}, 8'h00, "valid after time reset");
    wreg(8'h1D, 8'hFF);
    chk({7'h00, tv}, 8'h00, "valid set by write");
    rreg(8'h1D, d);
    chk(d, 8'h00, "first validity read");
    chk({7'h00, tv}, 8'h01, "valid after read");
    rreg(8'h1D, d);
    chk(d, 8'h80, "second validity read");
  endtask

  task automatic t_backup();
    ccl = 1'b1;
    osc = 1'b0;
    cyc(4);
    rreg(8'h1E, d);
    chk(d & 8'h03, 8'h02, "backup low and crystal");
    wreg(8'h1E, 8'h00);
    rreg(8'h1E, d);
    chk(d, 8'h00, "backup low cleared");
    ccl = 1'b0;
    osc = 1'b1;
    cyc(3);
    ccl = 1'b1;
    cyc(4);
    rreg(8'h1E, d);
    chk(d, 8'h03, "backup low again, rc source");
  endtask

  task automatic t_update();
    rreg(8'h1C, d);
    wreg(8'h1B, 8'h10);
    wait_tick();
    cyc(1);
    chk({7'h00, irq}, 8'h01, "update request");
    rreg(8'h1C, d);
    chk(d, 8'h90, "status with update");
    chk({7'h00, irq}, 8'h00, "request after read");
    wait_tick();
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (adv !== 1'b1 && t < 100);
    chk(t, 8'd16, "second length");
    wreg(8'h1B, 8'h00);
    wait_tick();
    cyc(1);
    chk({7'h00, irq}, 8'h00, "update masked");
    rreg(8'h1C, d);
    chk(d, 8'h10, "flag without request");
    wreg(8'h1B, 8'h80);
    chk({7'h00, setm}, 8'h01, "set mode output");
    count_ticks(48, t, db);
    chk(t, 8'h00, "ticks in set mode");
  endtask

  task automatic t_alarm();
    rreg(8'h1C, d);
    wreg(8'h1B, 8'hA0);
    am = 1'b1;
    cyc(3);
    chk({7'h00, irq}, 8'h01, "alarm request");
    rreg(8'h1C, d);
    chk(d, 8'hA0, "status with alarm");
    chk({7'h00, irq}, 8'h00, "alarm request cleared");
    am = 1'b0;
    wreg(8'h1B, 8'h80);
    am = 1'b1;
    cyc(3);
    chk({7'h00, irq}, 8'h00, "alarm masked");
    rreg(8'h1C, d);
    chk(d, 8'h20, "alarm flag only");
    am = 1'b0;
  endtask

  task automatic t_trim();
    wreg(8'h1B, 8'h00);
    wreg(8'h20, 8'h05);
    wreg(8'h1F, 8'h01);
    // A full 64-second window holds exactly magnitude trimmed seconds
    count_ticks(1024, t, db);
    chk(t, 8'd64, "add trim seconds");
    chk(db, 8'd5, "add trim doubles");
    wreg(8'h20, 8'h45);
    count_ticks(1024, t, db);
    chk(t, 8'd59, "subtract trim seconds");
    chk(db, 8'd0, "subtract trim doubles");
    wreg(8'h20, 8'h00);
    count_ticks(128, t, db);
    chk(t, 8'd8, "zero magnitude seconds");
    chk(db, 8'd0, "zero magnitude doubles");
    wreg(8'h20, 8'h3F);
    wreg(8'h1F, 8'h00);
    count_ticks(128, t, db);
    chk(t, 8'd8, "trim disabled seconds");
    chk(db, 8'd0, "trim disabled doubles");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_valid();
    t_backup();
    t_update();
    t_alarm();
    t_trim();
    test_done();
  end

  // Whole run needs about two and a half thousand cycles
  initial begin
    #(30000 * 50);
    err_count++;
    test_done();
  end
endmodule

// File: verilog/rstc_pkg.sv
// Package of register map, field positions, reset values and timing counts
package rstc_pkg;

  // Register addresses on the serial register port
  localparam logic [7:0] ADDR_CONTROL     = 8'h1B;
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h1C;
  localparam logic [7:0] ADDR_VALIDITY    = 8'h1D;
  localparam logic [7:0] ADDR_OSC_BACKUP  = 8'h1E;
  localparam logic [7:0] ADDR_CAL_ENABLE  = 8'h1F;
  localparam logic [7:0] ADDR_CAL_AMOUNT  = 8'h20;
  localparam logic [7:0] ADDR_SLOW_CLOCK_OUTPUT_MASK_MASK = 8'h21;

  // Reset values
  localparam logic [7:0] RST_CONTROL     = 8'h02;
  localparam logic [7:0] RST_INT_STATUS  = 8'h00;
  localparam logic [7:0] RST_VALIDITY    = 8'h00;
  localparam logic [7:0] RST_OSC_BACKUP  = 8'h05;
  localparam logic [7:0] RST_CAL_ENABLE  = 8'h00;
  localparam logic [7:0] RST_CAL_AMOUNT  = 8'h00;
  localparam logic [7:0] RST_SLOW_CLOCK_OUTPUT_MASK_MASK = 8'h00;

  // Control register fields
  localparam int unsigned CTRL_HOUR24_BIT = 1;
  localparam int unsigned CTRL_BINARY_BIT = 2;
  localparam int unsigned CTRL_UIE_BIT    = 4;
  localparam int unsigned CTRL_AIE_BIT    = 5;
  localparam int unsigned CTRL_SET_BIT    = 7;
  localparam logic [7:0]  CTRL_WMASK      = 8'hB6;

  // Interrupt status fields
  localparam int unsigned INT_UF_BIT   = 4;
  localparam int unsigned INT_AF_BIT   = 5;
  localparam int unsigned INT_INTERRUPT_REQUEST_FLAG_BIT = 7;

  // Validity field
  localparam int unsigned VALID_BIT = 7;

  // Oscillator and backup status fields
  localparam int unsigned OSC_SRC_BIT   = 0;
  localparam int unsigned BKLOW_BIT     = 1;
  localparam int unsigned POR_BIT       = 2;
  localparam int unsigned SCRATCH_LSB   = 3;
  localparam int unsigned SCRATCH_WIDTH = 5;

  // Calibration fields
  localparam int unsigned CAL_EN_BIT    = 0;
  localparam int unsigned CAL_MAG_WIDTH = 6;
  localparam int unsigned CAL_SIGN_BIT  = 6;
  localparam logic [7:0]  CAL_AMT_WMASK = 8'h7F;

  // Clock output mask field
  localparam int unsigned SLOW_CLOCK_OUTPUT_MASK_MASK_BIT = 0;

  // Timing: one update cycle per second
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned SECOND_NS       = 1000000000;
  localparam int unsigned SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_WIDTH  = 25;
  localparam int unsigned TRIM_WINDOW_SEC = 64;
  localparam int unsigned WINDOW_WIDTH    = 6;

endpackage

// File: verilog/rstc_top.sv
// Clock status flags, validity, calibration and clock output mask registers
`timescale 1ns/1ps
// How it works
// - Update-ended flag set after each update
// - Alarm flag set on alarm match
// - Request flag is enabled alarm or update
// - Time-valid reads zero after time reset
// - Only reading validity register sets time-valid
// - Bit0 shows crystal or RC source
// - Backup-low flag set on low coin cell
// - Reset flag shows power-on reset occurred
// - Five scratch bits, cleared by reset
// - Trim only while calibration enabled
// - Magnitude seconds adjusted per 64 seconds
// - Sign zero adds, one subtracts
// - Clock output driven unless mask set, and off in reset until the first clock
// - Update enable gates update-ended request
// - Alarm enable gates alarm request
// - One update per second outside set mode
module rstc_top #(
  parameter int unsigned SECOND_CYCLES_P = rstc_pkg::SECOND_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       alarm_match_i,
  input  wire logic       time_regs_reset_i,
  input  wire logic       coin_cell_low_i,
  input  wire logic       osc_rc_active_i,
  output logic [7:0]      reg_rdata_o,
  output logic            interrupt_request_o,
  output logic            time_advance_o,
  output logic            time_advance_double_o,
  output logic            set_mode_o,
  output logic            hour_24_mode_o,
  output logic            binary_mode_o,
  output logic            time_valid_o,
  output logic            slow_clk_out_en_o
);
  import rstc_pkg::*;

  // Register file
  logic [7:0]               control_ff;
  logic [7:0]               nxt_control;
  logic                     update_ended_flag_ff;
  logic                     nxt_update_ended_flag;
  logic                     alarm_flag_ff;
  logic                     nxt_alarm_flag;
  logic                     time_valid_bit_ff;
  logic                     nxt_time_valid_bit;
  logic                     backup_cell_low_flag_ff;
  logic                     nxt_backup_cell_low_flag;
  logic                     por_flag_ff;
  logic                     nxt_por_flag;
  logic [SCRATCH_WIDTH-1:0] scratch_ff;
  logic [SCRATCH_WIDTH-1:0] nxt_scratch;
  logic                     cal_enable_ff;
  logic                     nxt_cal_enable;
  logic [7:0]               cal_amount_ff;
  logic [7:0]               nxt_cal_amount;
  logic                     clk_mask_ff;
  logic                     nxt_clk_mask;
  logic [7:0]               rdata_ff;
  logic [7:0]               nxt_rdata;
  logic                     clk_en_ff;
  logic                     nxt_clk_en;

  // Pin synchronisers and edge memory
  logic [1:0]               sync_meta_ff;
  logic [1:0]               sync_ff;
  logic                     coin_low_prev_ff;
  logic                     alarm_prev_ff;

  logic                     wr_control;
  logic                     wr_osc_backup;
  logic                     wr_cal_enable;
  logic                     wr_cal_amount;
  logic                     wr_clk_mask;
  logic                     rd_int_status;
  logic                     rd_validity;
  logic                     coin_low_sync;
  logic                     osc_rc_sync;
  logic                     coin_low_rise;
  logic                     alarm_rise;
  logic                     update_done;
  logic                     update_ended_flag;
  logic                     alarm_flag;
  logic                     update_interrupt_enable;
  logic                     alarm_interrupt_enable;
  logic                     interrupt_request_flag;
  logic                     oscillator_source_status;
  logic [7:0]               int_status_word;
  logic [7:0]               validity_word;
  logic [7:0]               osc_backup_word;
  logic                     adv_pulse;
  logic                     adv_double;

  // Address decode; writes to read-only addresses fall on no register
  always_comb begin
    wr_control    = reg_wr_i && (reg_addr_i == ADDR_CONTROL);
    wr_osc_backup = reg_wr_i && (reg_addr_i == ADDR_OSC_BACKUP);
    wr_cal_enable = reg_wr_i && (reg_addr_i == ADDR_CAL_ENABLE);
    wr_cal_amount = reg_wr_i && (reg_addr_i == ADDR_CAL_AMOUNT);
    wr_clk_mask   = reg_wr_i && (reg_addr_i == ADDR_SLOW_CLOCK_OUTPUT_MASK_MASK);
    rd_int_status = reg_rd_i && (reg_addr_i == ADDR_INT_STATUS);
    rd_validity   = reg_rd_i && (reg_addr_i == ADDR_VALIDITY);
  end

  // Two-stage synchronisers for the comparator and oscillator-select pins
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_meta_ff <= {1'b1, 1'b0};
      sync_ff      <= {1'b1, 1'b0};
    end else begin
      sync_meta_ff <= {osc_rc_active_i, coin_cell_low_i};
      sync_ff      <= sync_meta_ff;
    end
  end

  assign coin_low_sync = sync_ff[0];
  assign osc_rc_sync   = sync_ff[1];

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      coin_low_prev_ff <= 1'b0;
      alarm_prev_ff    <= 1'b0;
    end else begin
      coin_low_prev_ff <= coin_low_sync;
      alarm_prev_ff    <= alarm_match_i;
    end
  end

  // Edges, so a held condition reports once and a cleared flag can rearm
  assign coin_low_rise = coin_low_sync && !coin_low_prev_ff;
  assign alarm_rise    = alarm_match_i && !alarm_prev_ff;

  rstc_trim #(
    .SECOND_CYCLES_P (SECOND_CYCLES_P)
  ) u_trim (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .run_i      (!control_ff[CTRL_SET_BIT]),
    .trim_en_i  (cal_enable_ff),
    .trim_mag_i (cal_amount_ff[CAL_MAG_WIDTH-1:0]),
    .trim_sub_i (cal_amount_ff[CAL_SIGN_BIT]),
    .advance_o  (adv_pulse),
    .double_o   (adv_double)
  );

  assign update_done = adv_pulse;

  // Flag and status terms
  always_comb begin
    update_ended_flag        = update_ended_flag_ff;
    alarm_flag               = alarm_flag_ff;
    update_interrupt_enable  = control_ff[CTRL_UIE_BIT];
    alarm_interrupt_enable   = control_ff[CTRL_AIE_BIT];
    interrupt_request_flag   = (alarm_flag && alarm_interrupt_enable) ||
                               (update_ended_flag && update_interrupt_enable);
    oscillator_source_status = osc_rc_sync;
    int_status_word               = 8'h00;
    int_status_word[INT_UF_BIT]   = update_ended_flag;
    int_status_word[INT_AF_BIT]   = alarm_flag;
    int_status_word[INT_INTERRUPT_REQUEST_FLAG_BIT] = interrupt_request_flag;
    validity_word            = 8'h00;
    validity_word[VALID_BIT] = time_valid_bit_ff;
    osc_backup_word              = 8'h00;
    osc_backup_word[OSC_SRC_BIT] = oscillator_source_status;
    osc_backup_word[BKLOW_BIT]   = backup_cell_low_flag_ff;
    osc_backup_word[POR_BIT]     = por_flag_ff;
    osc_backup_word[SCRATCH_LSB +: SCRATCH_WIDTH] = scratch_ff;
  end

  // Next state of the register file
  always_comb begin
    nxt_control              = control_ff;
    nxt_update_ended_flag    = update_ended_flag_ff;
    nxt_alarm_flag           = alarm_flag_ff;
    nxt_time_valid_bit       = time_valid_bit_ff;
    nxt_backup_cell_low_flag = backup_cell_low_flag_ff;
    nxt_por_flag             = por_flag_ff;
    nxt_scratch              = scratch_ff;
    nxt_cal_enable           = cal_enable_ff;
    nxt_cal_amount           = cal_amount_ff;
    nxt_clk_mask             = clk_mask_ff;

    if (wr_control) begin
      nxt_control = reg_wdata_i & CTRL_WMASK;
    end

    // Read-to-clear first, so a same-cycle event set overrides it
    if (rd_int_status) begin
      nxt_update_ended_flag = 1'b0;
      nxt_alarm_flag        = 1'b0;
    end
    if (update_done) begin
      nxt_update_ended_flag = 1'b1;
    end
    if (alarm_rise) begin
      nxt_alarm_flag = 1'b1;
    end

    // Only the read sets time-valid; a time reset in the same cycle wins
    if (rd_validity) begin
      nxt_time_valid_bit = 1'b1;
    end
    if (time_regs_reset_i) begin
      nxt_time_valid_bit = 1'b0;
    end

    if (wr_osc_backup) begin
      nxt_backup_cell_low_flag = reg_wdata_i[BKLOW_BIT];
      nxt_por_flag             = reg_wdata_i[POR_BIT];
      nxt_scratch              = reg_wdata_i[SCRATCH_LSB +: SCRATCH_WIDTH];
    end
    if (coin_low_rise) begin
      nxt_backup_cell_low_flag = 1'b1;
    end

    if (wr_cal_enable) begin
      nxt_cal_enable = reg_wdata_i[CAL_EN_BIT];
    end
    if (wr_cal_amount) begin
      nxt_cal_amount = reg_wdata_i & CAL_AMT_WMASK;
    end
    if (wr_clk_mask) begin
      nxt_clk_mask = reg_wdata_i[SLOW_CLOCK_OUTPUT_MASK_MASK_BIT];
    end
  end

  // Power-on reset loads the documented defaults; the reset flag starts at 1
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      control_ff              <= RST_CONTROL;
      update_ended_flag_ff    <= RST_INT_STATUS[INT_UF_BIT];
      alarm_flag_ff           <= RST_INT_STATUS[INT_AF_BIT];
      time_valid_bit_ff       <= RST_VALIDITY[VALID_BIT];
      backup_cell_low_flag_ff <= RST_OSC_BACKUP[BKLOW_BIT];
      por_flag_ff             <= RST_OSC_BACKUP[POR_BIT];
      scratch_ff              <= RST_OSC_BACKUP[SCRATCH_LSB +: SCRATCH_WIDTH];
      cal_enable_ff           <= RST_CAL_ENABLE[CAL_EN_BIT];
      cal_amount_ff           <= RST_CAL_AMOUNT;
      clk_mask_ff             <= RST_SLOW_CLOCK_OUTPUT_MASK_MASK[SLOW_CLOCK_OUTPUT_MASK_MASK_BIT];
    end else begin
      control_ff              <= nxt_control;
      update_ended_flag_ff    <= nxt_update_ended_flag;
      alarm_flag_ff           <= nxt_alarm_flag;
      time_valid_bit_ff       <= nxt_time_valid_bit;
      backup_cell_low_flag_ff <= nxt_backup_cell_low_flag;
      por_flag_ff             <= nxt_por_flag;
      scratch_ff              <= nxt_scratch;
      cal_enable_ff           <= nxt_cal_enable;
      cal_amount_ff           <= nxt_cal_amount;
      clk_mask_ff             <= nxt_clk_mask;
    end
  end

  // Read data is captured from the pre-access state, so a clearing read
  // still returns the flags it clears
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CONTROL: begin
          nxt_rdata = control_ff;
        end
        ADDR_INT_STATUS: begin
          nxt_rdata = int_status_word;
        end
        ADDR_VALIDITY: begin
          nxt_rdata = validity_word;
        end
        ADDR_OSC_BACKUP: begin
          nxt_rdata = osc_backup_word;
        end
        ADDR_CAL_ENABLE: begin
          nxt_rdata = {7'h00, cal_enable_ff};
        end
        ADDR_CAL_AMOUNT: begin
          nxt_rdata = cal_amount_ff;
        end
        ADDR_SLOW_CLOCK_OUTPUT_MASK_MASK: begin
          nxt_rdata = {7'h00, clk_mask_ff};
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // Mask reaches the output two cycles after the write; it gates an enable,
  // not the oscillator itself, so no glitchy clock gate lives here
  always_comb begin
    nxt_clk_en = !clk_mask_ff;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff  <= 8'h00;
      clk_en_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      clk_en_ff <= nxt_clk_en;
    end
  end

  assign reg_rdata_o           = rdata_ff;
  assign interrupt_request_o   = interrupt_request_flag;
  assign time_advance_o        = adv_pulse;
  assign time_advance_double_o = adv_double;
  assign set_mode_o            = control_ff[CTRL_SET_BIT];
  assign hour_24_mode_o        = control_ff[CTRL_HOUR24_BIT];
  assign binary_mode_o         = control_ff[CTRL_BINARY_BIT];
  assign time_valid_o          = time_valid_bit_ff;
  assign slow_clk_out_en_o     = clk_en_ff;

endmodule

// File: verilog/rstc_trim.sv
// Seconds prescaler with 64-second trim window
`timescale 1ns/1ps
module rstc_trim #(
  parameter int unsigned SECOND_CYCLES_P = rstc_pkg::SECOND_CYCLES
) (
  input  wire logic                              ref_clk_i,
  input  wire logic                              reset_i,
  input  wire logic                              run_i,
  input  wire logic                              trim_en_i,
  input  wire logic [rstc_pkg::CAL_MAG_WIDTH-1:0] trim_mag_i,
  input  wire logic                              trim_sub_i,
  output logic                                   advance_o,
  output logic                                   double_o
);
  import rstc_pkg::*;

  logic [PRESCALE_WIDTH-1:0] presc_ff;
  logic [PRESCALE_WIDTH-1:0] nxt_presc;
  logic [WINDOW_WIDTH-1:0]   win_ff;
  logic [WINDOW_WIDTH-1:0]   nxt_win;
  logic                      adv_ff;
  logic                      nxt_adv;
  logic                      dbl_ff;
  logic                      nxt_dbl;
  logic                      sec_tick;
  logic                      in_trim;

  localparam logic [PRESCALE_WIDTH-1:0] PRESC_LAST =
    PRESCALE_WIDTH'(SECOND_CYCLES_P - 1);

  always_comb begin
    sec_tick  = run_i && (presc_ff == PRESC_LAST);
    // First trim_mag seconds of each window are the adjusted ones
    in_trim   = trim_en_i && (win_ff < trim_mag_i);
    nxt_presc = presc_ff;
    nxt_win   = win_ff;
    nxt_adv   = 1'b0;
    nxt_dbl   = 1'b0;
    if (!run_i) begin
      // Set mode aborts the second in progress
      nxt_presc = '0;
    end else if (sec_tick) begin
      nxt_presc = '0;
      nxt_win   = win_ff + 1'b1;
      if (in_trim && trim_sub_i) begin
        nxt_adv = 1'b0;
      end else begin
        nxt_adv = 1'b1;
        nxt_dbl = in_trim;
      end
    end else begin
      nxt_presc = presc_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      presc_ff <= '0;
      win_ff   <= '0;
      adv_ff   <= 1'b0;
      dbl_ff   <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      win_ff   <= nxt_win;
      adv_ff   <= nxt_adv;
      dbl_ff   <= nxt_dbl;
    end
  end

  assign advance_o = adv_ff;
  assign double_o  = dbl_ff;

endmodule
